//--- rtl/rpp_pkg.sv
// package of constants for the register page pointer block
// assumes one core clock and an 8-bit register address space
package rpp_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int NIBBLE_W = 4;
  localparam int PAGE_W = 3;
  localparam int NUM_PAGES = 8;
  // ************************************************
  // pointer register, set 1
  // ************************************************
  localparam logic [ADDR_W-1:0] PTR_OFFSET = 8'hDF;
  localparam logic [DATA_W-1:0] PTR_RESET = 8'h00;
  localparam int DST_MSB = 7;
  localparam int DST_LSB = 4;
  localparam int SRC_MSB = 3;
  localparam int SRC_LSB = 0;
  // ************************************************
  // page roles
  // ************************************************
  localparam logic [PAGE_W-1:0] DISPLAY_PAGE = 3'h4;
  localparam logic [NIBBLE_W-1:0] LAST_PAGE = 4'h7;
  localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;
endpackage : rpp_pkg

//--- rtl/rpp_page_mem.sv
// paged register file storage, one write port and two read ports
// assumes the caller supplies page-qualified addresses
`timescale 1ns/1ps
module rpp_page_mem #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 11
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic rd_a_en,
  input wire logic [ADDR_W-1:0] rd_a_addr,
  output logic [DATA_W-1:0] rd_a_data,
  input wire logic rd_b_en,
  input wire logic [ADDR_W-1:0] rd_b_addr,
  output logic [DATA_W-1:0] rd_b_data
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // ************************************************
  // storage and registered reads
  // ************************************************
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rd_a_en) begin
      rd_a_data <= mem[rd_a_addr];
    end
  end

  always_ff @(posedge clk) begin
    if (rd_b_en) begin
      rd_b_data <= mem[rd_b_addr];
    end
  end
endmodule : rpp_page_mem

//--- rtl/rpp_register_page_pointer.sv
// register page pointer with the eight-page register file it steers
// assumes the core presents one register access per cycle, synchronous to clk
//
// Behaviour
// - upper nibble selects destination page for writes
// - destination nibble decodes as binary page number
// - register file holds eight selectable pages
// - pages zero to seven are general storage
// - page four also feeds the display driver
// - pointer at DF set 1, register addressing only
`timescale 1ns/1ps
module rpp_register_page_pointer #(
  parameter int PAGE_BYTES_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic acc_set1,
  input wire logic acc_indirect,
  input wire logic [rpp_pkg::ADDR_W-1:0] acc_addr,
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [rpp_pkg::DATA_W-1:0] acc_wdata,
  output logic [rpp_pkg::DATA_W-1:0] acc_rdata,
  output logic acc_rvalid,
  output logic [rpp_pkg::NIBBLE_W-1:0] dst_page,
  output logic [rpp_pkg::NIBBLE_W-1:0] src_page,
  input wire logic disp_rd,
  input wire logic [PAGE_BYTES_W-1:0] disp_addr,
  output logic [rpp_pkg::DATA_W-1:0] disp_rdata,
  output logic disp_rvalid
);
  import rpp_pkg::*;

  localparam int MEM_AW = PAGE_W + PAGE_BYTES_W;

  // ************************************************
  // helper functions
  // ************************************************
  function automatic logic page_ok(input logic [NIBBLE_W-1:0] nib);
    page_ok = (nib <= LAST_PAGE);
  endfunction : page_ok

  function automatic logic [PAGE_W-1:0] page_num(input logic [NIBBLE_W-1:0] nib);
    page_num = nib[PAGE_W-1:0];
  endfunction : page_num

  function automatic logic [MEM_AW-1:0] page_addr(input logic [PAGE_W-1:0] page,
                                                  input logic [ADDR_W-1:0] off);
    page_addr = {page, off[PAGE_BYTES_W-1:0]};
  endfunction : page_addr

  // ************************************************
  // reset release
  // ************************************************
  logic rst_s1_reg;
  logic rst_s2_reg;
  logic sys_rst_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'h0;
    end else begin
      rst_s1_reg <= 1'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s2_reg <= 1'h0;
    end else begin
      rst_s2_reg <= rst_s1_reg;
    end
  end

  assign sys_rst_n = rst_s2_reg;

  // ************************************************
  // access decode
  // ************************************************
  logic direct_acc;
  logic ptr_addr_hit;
  logic ptr_hit;
  logic file_acc;
  logic ptr_wr;
  logic ptr_rd;

  assign direct_acc = !acc_indirect;
  assign ptr_addr_hit = (acc_addr == PTR_OFFSET);
  assign ptr_hit = acc_set1 && direct_acc && ptr_addr_hit;
  assign file_acc = !acc_set1;
  assign ptr_wr = acc_wr && ptr_hit;
  assign ptr_rd = acc_rd && ptr_hit;

  // ************************************************
  // pointer register
  // ************************************************
  logic [DATA_W-1:0] ptr_reg;
  logic [DATA_W-1:0] ptr_next;

  assign ptr_next = ptr_wr ? acc_wdata : ptr_reg;

  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      ptr_reg <= PTR_RESET;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  // ************************************************
  // page selectors
  // ************************************************
  logic [NIBBLE_W-1:0] dst_nib;
  logic [NIBBLE_W-1:0] src_nib;
  logic [PAGE_W-1:0] dst_pg;
  logic [PAGE_W-1:0] src_pg;
  logic dst_ok;
  logic src_ok;

  assign dst_nib = ptr_reg[DST_MSB:DST_LSB];
  assign src_nib = ptr_reg[SRC_MSB:SRC_LSB];
  assign dst_pg = page_num(dst_nib);
  assign src_pg = page_num(src_nib);
  assign dst_ok = page_ok(dst_nib);
  assign src_ok = page_ok(src_nib);
  assign dst_page = dst_nib;
  assign src_page = src_nib;

  // ************************************************
  // file strobes and addresses
  // ************************************************
  logic file_wr;
  logic file_rd;
  logic [MEM_AW-1:0] wr_addr;
  logic [MEM_AW-1:0] rd_addr;
  logic [MEM_AW-1:0] disp_maddr;

  assign file_wr = acc_wr && file_acc && dst_ok;
  assign file_rd = acc_rd && file_acc && src_ok;
  assign wr_addr = page_addr(dst_pg, acc_addr);
  assign rd_addr = page_addr(src_pg, acc_addr);
  assign disp_maddr = {DISPLAY_PAGE, disp_addr};

  // ************************************************
  // paged storage
  // ************************************************
  logic [DATA_W-1:0] mem_rdata;

  rpp_page_mem #(
    .DATA_W(DATA_W),
    .ADDR_W(MEM_AW)
  ) i_rpp_page_mem (
    .clk(clk),
    .wr_en(file_wr),
    .wr_addr(wr_addr),
    .wr_data(acc_wdata),
    .rd_a_en(file_rd),
    .rd_a_addr(rd_addr),
    .rd_a_data(mem_rdata),
    .rd_b_en(disp_rd),
    .rd_b_addr(disp_maddr),
    .rd_b_data(disp_rdata)
  );

  // ************************************************
  // read return, one cycle after the request
  // ************************************************
  logic rvalid_reg;
  logic sel_mem_reg;
  logic sel_ptr_reg;
  logic [DATA_W-1:0] ptr_cap_reg;
  logic disp_valid_reg;

  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      rvalid_reg <= 1'h0;
    end else begin
      rvalid_reg <= acc_rd;
    end
  end

  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      sel_mem_reg <= 1'h0;
    end else begin
      sel_mem_reg <= file_rd;
    end
  end

  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      sel_ptr_reg <= 1'h0;
    end else begin
      sel_ptr_reg <= ptr_rd;
    end
  end

  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      ptr_cap_reg <= PTR_RESET;
    end else if (ptr_rd) begin
      ptr_cap_reg <= ptr_reg;
    end
  end

  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      disp_valid_reg <= 1'h0;
    end else begin
      disp_valid_reg <= disp_rd;
    end
  end

  // ************************************************
  // read data outputs
  // ************************************************
  logic [DATA_W-1:0] ptr_rdata;

  assign ptr_rdata = sel_ptr_reg ? ptr_cap_reg : READ_IDLE;
  assign acc_rvalid = rvalid_reg;
  assign acc_rdata = sel_mem_reg ? mem_rdata : ptr_rdata;
  assign disp_rvalid = disp_valid_reg;
endmodule : rpp_register_page_pointer

//--- verif/rpp_register_page_pointer_sva.sv
// port checks for the register page pointer
// assumes binding onto rpp_register_page_pointer
`timescale 1ns/1ps
module rpp_sva import rpp_pkg::*; #(parameter int PAGE_BYTES_W = 8) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic acc_set1,
  input wire logic acc_indirect,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [DATA_W-1:0] acc_wdata,
  input wire logic [DATA_W-1:0] acc_rdata,
  input wire logic acc_rvalid,
  input wire logic [NIBBLE_W-1:0] dst_page,
  input wire logic [NIBBLE_W-1:0] src_page,
  input wire logic disp_rd,
  input wire logic [PAGE_BYTES_W-1:0] disp_addr,
  input wire logic [DATA_W-1:0] disp_rdata,
  input wire logic disp_rvalid
);
  // ************
  // assertions
  // ************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic ptr = acc_set1 && !acc_indirect && acc_addr == PTR_OFFSET;
  sequence s_wr;
    acc_wr && !acc_set1 && dst_page == src_page && dst_page < 4'h7;
  endsequence
  sequence s_rd;
    acc_rd && !acc_set1 && acc_addr == $past(acc_addr, 2) && src_page == $past(src_page, 2);
  endsequence
  chk_ptr_write: assert property (acc_wr && ptr |=> {dst_page, src_page} == $past(acc_wdata))
    else $error("pointer write not taken");
  chk_ptr_hold: assert property (!(acc_wr && ptr) |=> $stable({dst_page, src_page}))
    else $error("pointer changed without write");
  chk_ptr_read: assert property (acc_rd && ptr |=> acc_rdata == {$past(dst_page), $past(src_page)})
    else $error("pointer read wrong");
  chk_rd_answer: assert property (acc_rvalid == $past(acc_rd))
    else $error("read valid timing wrong");
  chk_reset_zero: assert property ($rose(rst_n) |-> dst_page == 4'h0 && src_page == 4'h0)
    else $error("pointer not zero after reset");
  chk_bad_page: assert property (acc_rd && !acc_set1 && src_page > LAST_PAGE |=> acc_rdata == 8'h00)
    else $error("invalid page read not zero");
  chk_page_store: assert property (s_wr ##1 !acc_wr ##1 s_rd |=> acc_rdata == $past(acc_wdata, 3))
    else $error("page data not kept");
  chk_set1_miss: assert property (acc_rd && acc_set1 && !ptr |=> acc_rdata == READ_IDLE)
    else $error("unmatched set 1 read not zero");
  chk_disp_answer: assert property (disp_rvalid == $past(disp_rd))
    else $error("display valid timing wrong");
endmodule : rpp_sva
bind rpp_register_page_pointer rpp_sva #(.PAGE_BYTES_W(PAGE_BYTES_W)) i_rpp_sva (
  .clk(clk),
  .rst_n(rst_n),
  .acc_set1(acc_set1),
  .acc_indirect(acc_indirect),
  .acc_addr(acc_addr),
  .acc_wr(acc_wr),
  .acc_rd(acc_rd),
  .acc_wdata(acc_wdata),
  .acc_rdata(acc_rdata),
  .acc_rvalid(acc_rvalid),
  .dst_page(dst_page),
  .src_page(src_page),
  .disp_rd(disp_rd),
  .disp_addr(disp_addr),
  .disp_rdata(disp_rdata),
  .disp_rvalid(disp_rvalid)
);

//--- verif/rpp_register_page_pointer_bench.sv
// self-checking bench for the register page pointer
// assumes the checker is bound separately
`timescale 1ns/1ps
module rpp_register_page_pointer_bench;
  import rpp_pkg::*;
  logic clk = 0, rst_n = 0, s1 = 0, ind = 0, wr = 0, rd = 0, drd = 0;
  logic [7:0] addr = 0, wd = 0, da = 0;
  wire logic [7:0] rdat, ddat;
  wire logic rv, dv;
  wire logic [3:0] dp, sp;
  int fails = 0, check_count = 0, cyc = 0;
  always #12.5 clk = ~clk;
  rpp_register_page_pointer i_rpp_register_page_pointer (.clk(clk), .rst_n(rst_n), .acc_set1(s1),
    .acc_indirect(ind), .acc_addr(addr), .acc_wr(wr), .acc_rd(rd), .acc_wdata(wd), .acc_rdata(rdat),
    .acc_rvalid(rv), .dst_page(dp), .src_page(sp), .disp_rd(drd), .disp_addr(da), .disp_rdata(ddat),
    .disp_rvalid(dv));
  // ************
  // tasks
  // ************
  task chk(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task acc(logic s, w, r, logic [7:0] a, d);
    @(posedge clk);
    #1 {s1, wr, rd, addr, wd} = {s, w, r, a, d};
    @(posedge clk);
    #1 {wr, rd} = 2'b00;
  endtask : acc
  task t_ptr;
    chk("dst", 8'h00, {4'h0, dp});
    acc(1, 1, 0, 8'hDF, 8'h52);
    chk("dst", 8'h05, {4'h0, dp});
    chk("src", 8'h02, {4'h0, sp});
    ind = 1;
    acc(1, 1, 0, 8'hDF, 8'h00);
    ind = 0;
    acc(1, 0, 1, 8'hDF, 8'h00);
    chk("ptr", 8'h52, rdat);
    acc(1, 0, 1, 8'hDE, 8'h00);
    chk("other", 8'h00, rdat);
    acc(1, 1, 0, 8'hDF, 8'h88);
    acc(0, 0, 1, 8'h10, 8'h00);
    chk("bad", 8'h00, rdat);
    chk("rvalid", 8'h01, {7'h00, rv});
    $display("t_ptr done");
  endtask : t_ptr
  task t_pages;
    for (int p = 0; p < 8; p++) begin
      acc(1, 1, 0, 8'hDF, {p[3:0], p[3:0]});
      acc(0, 1, 0, 8'h10, 8'hA0 + p[7:0]);
      acc(0, 0, 1, 8'h10, 8'h00);
      chk("page", 8'hA0 + p[7:0], rdat);
    end
    for (int p = 0; p < 8; p++) begin
      acc(1, 1, 0, 8'hDF, {4'h0, p[3:0]});
      acc(0, 0, 1, 8'h10, 8'h00);
      chk("src", 8'hA0 + p[7:0], rdat);
    end
    @(posedge clk);
    #1 {drd, da} = {1'b1, 8'h10};
    @(posedge clk);
    #1 drd = 0;
    chk("disp", 8'hA4, ddat);
    chk("dvalid", 8'h01, {7'h00, dv});
    $display("t_pages done");
  endtask : t_pages
  task t_refuse;
    acc(1, 1, 0, 8'hDF, 8'h80);
    acc(0, 1, 0, 8'h10, 8'h55);
    acc(0, 0, 1, 8'h10, 8'h00);
    chk("nowrite", 8'hA0, rdat);
    $display("t_refuse done");
  endtask : t_refuse
  task t_reset;
    acc(1, 1, 0, 8'hDF, 8'h31);
    chk("preset", 8'h31, {dp, sp});
    @(posedge clk);
    #1 rst_n = 1'h0;
    #1 chk("inreset", 8'h00, {dp, sp});
    repeat (2) @(posedge clk);
    #1 rst_n = 1'h1;
    repeat (3) @(posedge clk);
    chk("reset", 8'h00, {dp, sp});
    $display("t_reset done");
  endtask : t_reset
  task final_report;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cyc++;
    if (cyc > 1000) begin
      fails++;
      final_report;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    repeat (3) @(posedge clk);
    t_ptr;
    t_pages;
    t_refuse;
    t_reset;
    final_report;
  end
endmodule : rpp_register_page_pointer_bench
